// File: rtl/sar_adc_conversion_control.sv
// control logic of a 10-bit successive-approximation converter
// assumes: all inputs synchronous to core_clk; the analog comparator
// answers compHigh for the code on dacCode_ff; read strobes are pulses
//
// How it works
// - input at upper reference gives 3ff, at lower 000, linear between
// - a status and control write starts a conversion unless channel select is all ones
// - a conversion takes 16 to 17 converter clock cycles
// - continuous mode overwrites results after every conversion that the read interlock does not block
// - continuous enable repeats conversions back to back until cleared
// - without interrupts the complete flag sets at end, clears on result read
// - single mode does one conversion per write, then idles
// - two format bits in the clock register choose one of four formats
// - left format: top eight bits high, two low bits low
// - reading high blocks storage until low is read; read low after high
// - right format: top two bits high, low eight bits low
// - left signed format: as left, top result bit inverted
// - truncated format: top eight bits in low, no interlock
// - with interrupt enabled, request per conversion, flag reads zero
// - converting continues in wait; enabled interrupt can wake
// - stop aborts conversion; conversions resume after stop ends
// - channel select all ones turns the converter off
// - converter clock is the selected input clock divided per divider field
// - result read or status write clears a pending interrupt request
// - reading high freezes low until low has been read
`include "sar_adc_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module sar_adc_conversion_control (
  input  wire logic                       core_clk,            // 20 MHz core clock
  input  wire logic                       rst,                 // sync reset, high
  input  wire logic                       scrWrite,            // status reg write pulse
  input  wire sar_adc_pkg::status_ctrl_t  scrData,             // status reg write data
  input  wire logic                       clkRegWrite,         // clock reg write pulse
  input  wire sar_adc_pkg::clock_reg_t    clkRegData,          // clock reg write data
  input  wire logic                       highRead,            // high result read pulse
  input  wire logic                       lowRead,             // low result read pulse
  input  wire logic                       busTick,             // bus clock tick
  input  wire logic                       oscTick,             // oscillator tick
  input  wire logic                       waitMode,            // cpu in wait
  input  wire logic                       stopMode,            // cpu in stop
  input  wire logic                       compHigh,            // input >= dac code
  output sar_adc_pkg::status_ctrl_t       statusCtrl_ff,       // status reg readback
  output logic                            completeFlag_ff,     // conversion complete flag
  output sar_adc_pkg::clock_reg_t         clockReg_ff,         // clock reg readback
  output logic [7:0]                      resultHigh_ff,       // high result register
  output logic [7:0]                      resultLow_ff,        // low result register
  output logic                            irqRequest_ff,       // completion interrupt
  output logic                            wakeRequest_ff,      // wake from wait
  output logic [`SAR_RESULT_BITS-1:0]     dacCode_ff,          // trial code to dac
  output logic                            sampleEnable_ff,     // sample switch closed
  output logic                            converterOn_ff       // analog power on
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [3:0] divMask(input logic [2:0] div);
    logic [3:0] m;
    m = 4'h0;
    if (div[2]) begin
      m = 4'hf;
    end else begin
      unique case (div[1:0])
        2'h0: m = 4'h0;
        2'h1: m = 4'h1;
        2'h2: m = 4'h3;
        2'h3: m = 4'h7;
      endcase
    end
    return m;
  endfunction

  function automatic logic isInterlocked(input sar_adc_pkg::format_t f);
    return f != sar_adc_pkg::FMT_TRUNC8;
  endfunction

  function automatic sar_adc_pkg::result_pair_t formatResult(
    input logic [`SAR_RESULT_BITS-1:0] code,
    input sar_adc_pkg::format_t        f
  );
    sar_adc_pkg::result_pair_t r;
    r = '0;
    unique case (f)
      sar_adc_pkg::FMT_LEFT: begin
        r.high = code[9:2];
        r.low  = {code[1:0], 6'h00};
      end
      sar_adc_pkg::FMT_RIGHT: begin
        r.high = {6'h00, code[9:8]};
        r.low  = code[7:0];
      end
      sar_adc_pkg::FMT_LEFT_SIGNED: begin
        r.high = {~code[9], code[8:2]};
        r.low  = {code[1:0], 6'h00};
      end
      sar_adc_pkg::FMT_TRUNC8: begin
        r.low  = code[9:2];
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sar_adc_pkg::conv_state_t state_ff;
  sar_adc_pkg::conv_state_t nxt_state;
  logic [3:0]               tickCnt_ff;
  logic [3:0]               nxt_tickCnt;
  logic [3:0]               divCnt_ff;
  logic [3:0]               bitIdx;
  logic                     srcTick;
  logic                     convTick;
  logic                     convDone;
  logic                     runPending_ff;
  logic                     lock_ff;
  logic                     resultAccess;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // flag bit of the written value is ignored; it is not writable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      statusCtrl_ff.completionIrqEnable <= 1'b0;
      statusCtrl_ff.continuousEnable    <= 1'b0;
      statusCtrl_ff.channelSelect       <= `SAR_RST_CHANNEL;
    end else if (scrWrite) begin
      statusCtrl_ff <= scrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clockReg_ff.formatSelect     <= sar_adc_pkg::FMT_LEFT;
      clockReg_ff.inputClockSource <= `SAR_RST_CLK_SRC;
      clockReg_ff.clockDivider     <= `SAR_RST_DIVIDER;
    end else if (clkRegWrite) begin
      clockReg_ff <= clkRegData;
    end
  end

  // power follows the written channel so it is known with the write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      converterOn_ff <= 1'b0;
    end else if (scrWrite) begin
      converterOn_ff <= scrData.channelSelect != `SAR_CHANNEL_OFF;
    end
  end

  // ----------------------------------------------------------------
  // converter clock
  // ----------------------------------------------------------------
  // ticks, not a real clock: keeps the block in one clock domain
  assign srcTick = clockReg_ff.inputClockSource ? busTick : oscTick;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      divCnt_ff <= 4'h0;
    end else if (srcTick) begin
      divCnt_ff <= divCnt_ff + 4'h1;
    end
  end

  assign convTick = srcTick &&
    ((divCnt_ff & divMask(clockReg_ff.clockDivider)) ==
      divMask(clockReg_ff.clockDivider));

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  // armed waits for the first tick, hence 16 or 17 converter periods
  assign convDone = (state_ff == sar_adc_pkg::ST_CONVERT) && convTick &&
                    (tickCnt_ff == `SAR_LAST_TICK);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      runPending_ff <= 1'b0;
    end else if (scrWrite) begin
      runPending_ff <= scrData.channelSelect != `SAR_CHANNEL_OFF;
    end else if (!converterOn_ff) begin
      runPending_ff <= 1'b0;
    end else if (convDone && !statusCtrl_ff.continuousEnable) begin
      runPending_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_state   = state_ff;
    nxt_tickCnt = tickCnt_ff;
    if (stopMode || !converterOn_ff || scrWrite) begin
      // abort; a pending run re-arms once stop ends
      nxt_state   = sar_adc_pkg::ST_IDLE;
      nxt_tickCnt = 4'h0;
    end else begin
      unique case (state_ff)
        sar_adc_pkg::ST_IDLE: begin
          if (runPending_ff) begin
            nxt_state = sar_adc_pkg::ST_ARMED;
          end
        end
        sar_adc_pkg::ST_ARMED: begin
          if (convTick) begin
            nxt_state   = sar_adc_pkg::ST_CONVERT;
            nxt_tickCnt = 4'h0;
          end
        end
        sar_adc_pkg::ST_CONVERT: begin
          if (convDone) begin
            nxt_state   = sar_adc_pkg::ST_IDLE;
            nxt_tickCnt = 4'h0;
          end else if (convTick) begin
            nxt_tickCnt = tickCnt_ff + 4'h1;
          end
        end
        default: begin
          nxt_state = sar_adc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff   <= sar_adc_pkg::ST_IDLE;
      tickCnt_ff <= 4'h0;
    end else begin
      state_ff   <= nxt_state;
      tickCnt_ff <= nxt_tickCnt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sampleEnable_ff <= 1'b0;
    end else begin
      sampleEnable_ff <= (nxt_state == sar_adc_pkg::ST_CONVERT) &&
                         (nxt_tickCnt < `SAR_SAMPLE_TICKS);
    end
  end

  // ----------------------------------------------------------------
  // successive approximation
  // ----------------------------------------------------------------
  // bit decided at a tick is the one trialled during the tick before
  assign bitIdx = `SAR_LAST_TRIAL - tickCnt_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dacCode_ff <= `SAR_CODE_ZERO;
    end else if (nxt_state != sar_adc_pkg::ST_CONVERT && !convDone) begin
      dacCode_ff <= `SAR_CODE_ZERO;
    end else if (convTick && state_ff == sar_adc_pkg::ST_CONVERT &&
                 tickCnt_ff >= `SAR_SAMPLE_TICKS - 4'h1 &&
                 tickCnt_ff <= `SAR_LAST_TRIAL) begin
      if (tickCnt_ff >= `SAR_SAMPLE_TICKS) begin
        dacCode_ff[bitIdx] <= compHigh;
      end
      if (bitIdx != 4'h0) begin
        dacCode_ff[4'(bitIdx - 4'h1)] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // result registers and interlock
  // ----------------------------------------------------------------
  // set wins over the low read so a high read is never missed
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lock_ff <= 1'b0;
    end else if (highRead && isInterlocked(clockReg_ff.formatSelect)) begin
      lock_ff <= 1'b1;
    end else if (lowRead) begin
      lock_ff <= 1'b0;
    end
  end

  // results blocked while locked are lost, not queued
  always_ff @(posedge core_clk) begin
    if (rst) begin
      resultHigh_ff <= `SAR_RST_RESULT;
      resultLow_ff  <= `SAR_RST_RESULT;
    end else if (convDone &&
                 !(lock_ff && isInterlocked(clockReg_ff.formatSelect))) begin
      {resultHigh_ff, resultLow_ff} <=
        formatResult(dacCode_ff, clockReg_ff.formatSelect);
    end
  end

  // ----------------------------------------------------------------
  // completion flag and interrupt
  // ----------------------------------------------------------------
  assign resultAccess = highRead || lowRead;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      completeFlag_ff <= 1'b0;
    end else if (statusCtrl_ff.completionIrqEnable) begin
      completeFlag_ff <= 1'b0;
    end else if (convDone) begin
      completeFlag_ff <= 1'b1;
    end else if (resultAccess) begin
      completeFlag_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqRequest_ff <= 1'b0;
    end else if (convDone && statusCtrl_ff.completionIrqEnable) begin
      irqRequest_ff <= 1'b1;
    end else if (resultAccess || scrWrite) begin
      irqRequest_ff <= 1'b0;
    end else if (!statusCtrl_ff.completionIrqEnable) begin
      irqRequest_ff <= 1'b0;
    end
  end

  // wait does not gate conversion; only stop does
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wakeRequest_ff <= 1'b0;
    end else begin
      wakeRequest_ff <= waitMode && irqRequest_ff;
    end
  end

endmodule

`default_nettype wire

// File: rtl/sar_adc_defs.svh
// constants of the successive-approximation converter control block
// assumes: included by its bare name from the design files
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH

// ----------------------------------------------------------------
// conversion sequence, counted in converter clock ticks
// ----------------------------------------------------------------
`define SAR_RESULT_BITS   10
`define SAR_SAMPLE_TICKS  4'h5
`define SAR_LAST_TRIAL    4'he
`define SAR_LAST_TICK     4'hf

// ----------------------------------------------------------------
// codes and field values
// ----------------------------------------------------------------
`define SAR_CODE_FULL     10'h3ff
`define SAR_CODE_ZERO     10'h000
`define SAR_CHANNEL_OFF   5'h1f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SAR_RST_CHANNEL   5'h1f
`define SAR_RST_DIVIDER   3'h0
`define SAR_RST_CLK_SRC   1'h0
`define SAR_RST_RESULT    8'h00

`endif

// File: rtl/sar_adc_pkg.sv
// types shared by the converter control block and its bench
// assumes: nothing beyond a SystemVerilog compiler
package sar_adc_pkg;

  // format codes 0..3: left, right, left signed, 8-bit truncated
  typedef enum logic [1:0] {
    FMT_LEFT,
    FMT_RIGHT,
    FMT_LEFT_SIGNED,
    FMT_TRUNC8
  } format_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_CONVERT
  } conv_state_t;

  // status and control register, writable fields
  typedef struct packed {
    logic       completionIrqEnable;
    logic       continuousEnable;
    logic [4:0] channelSelect;
  } status_ctrl_t;

  // converter clock register
  typedef struct packed {
    format_t    formatSelect;     // {format_select_hi, format_select_lo}
    logic       inputClockSource; // 1 = bus tick, 0 = oscillator tick
    logic [2:0] clockDivider;
  } clock_reg_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_pair_t;

endpackage

// File: dv/sar_adc_analog_model.sv
// comparator model standing behind the converter control block
// assumes: the bench gives the selected input as an ideal 10-bit code
`timescale 1ns/1ns
`default_nettype none

module sar_adc_analog_model (
  input  wire logic       core_clk,    // core clock
  input  wire logic [9:0] inputCode,   // selected input as a code
  input  wire logic [9:0] dacCode,     // trial code from the control
  input  wire logic       converterOn, // analog power
  output logic            compHigh     // input at or above trial code
);
  logic noise_ff = 1'b0;

  // powered-down comparator has no defined answer, so it chatters
  always_ff @(posedge core_clk) begin
    noise_ff <= ~noise_ff;
  end

  assign compHigh = converterOn ? (inputCode >= dacCode) : noise_ff;
endmodule

`default_nettype wire

// File: dv/sar_adc_conversion_control_checker.sv
// assertions on the ports of the converter control block
// assumes: bound into sar_adc_conversion_control, one clock domain
`include "sar_adc_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module sar_adc_conversion_control_checker (
  input wire logic                       core_clk,        // core clock
  input wire logic                       rst,             // sync reset
  input wire logic                       scrWrite,        // status write
  input wire sar_adc_pkg::status_ctrl_t  scrData,         // status data
  input wire logic                       highRead,        // high read
  input wire logic                       lowRead,         // low read
  input wire logic                       waitMode,        // cpu wait
  input wire logic                       stopMode,        // cpu stop
  input wire sar_adc_pkg::status_ctrl_t  statusCtrl_ff,   // status readback
  input wire logic                       completeFlag_ff, // complete flag
  input wire sar_adc_pkg::clock_reg_t    clockReg_ff,     // clock register
  input wire logic [7:0]                 resultHigh_ff,   // high result
  input wire logic [7:0]                 resultLow_ff,    // low result
  input wire logic                       irqRequest_ff,   // interrupt
  input wire logic                       wakeRequest_ff,  // wake request
  input wire logic [`SAR_RESULT_BITS-1:0] dacCode_ff,     // trial code
  input wire logic                       sampleEnable_ff, // sampling
  input wire logic                       converterOn_ff   // analog power
);
  logic lock_ff;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // -------------------------------------------------------------
  // read interlock shadow
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lock_ff <= 1'b0;
    end else if (highRead && clockReg_ff.formatSelect != sar_adc_pkg::FMT_TRUNC8) begin
      lock_ff <= 1'b1;
    end else if (lowRead) begin
      lock_ff <= 1'b0;
    end
  end

  lock_hold_a: assert property ($past(lock_ff)
    && $past(clockReg_ff.formatSelect) != sar_adc_pkg::FMT_TRUNC8
    |-> $stable(resultHigh_ff) && $stable(resultLow_ff)) else $error("results moved while locked");
  flag_irq_off_a: assert property (statusCtrl_ff.completionIrqEnable
    && $past(statusCtrl_ff.completionIrqEnable) |-> !completeFlag_ff) else $error("flag set with irq");
  flag_clear_a: assert property ($fell(completeFlag_ff)
    |-> $past(highRead || lowRead || rst)
    || $past(statusCtrl_ff.completionIrqEnable) || statusCtrl_ff.completionIrqEnable)
    else $error("flag cleared without read");
  irq_clear_a: assert property ($fell(irqRequest_ff)
    |-> $past(highRead || lowRead || scrWrite || rst)
    || !statusCtrl_ff.completionIrqEnable) else $error("irq dropped without cause");
  irq_enabled_a: assert property ($rose(irqRequest_ff)
    |-> $past(statusCtrl_ff.completionIrqEnable)) else $error("irq while disabled");
  wake_follow_a: assert property (waitMode && irqRequest_ff |=> wakeRequest_ff)
    else $error("no wake request");
  power_field_a: assert property (scrWrite |=> converterOn_ff
    == ($past(scrData.channelSelect) != `SAR_CHANNEL_OFF)) else $error("power state wrong");
  off_idle_a: assert property (!converterOn_ff && $past(!converterOn_ff)
    |-> !sampleEnable_ff) else $error("sampling while off");
  stop_abort_a: assert property (stopMode && $past(stopMode) && $past(stopMode, 2)
    |-> dacCode_ff == '0 && !sampleEnable_ff) else $error("converting in stop");
  trunc_high_a: assert property ($changed(resultLow_ff)
    && $past(clockReg_ff.formatSelect) == sar_adc_pkg::FMT_TRUNC8 |-> resultHigh_ff == 8'h00)
    else $error("high not zero in trunc");
endmodule

bind sar_adc_conversion_control sar_adc_conversion_control_checker chk (
  .core_clk(core_clk), .rst(rst), .scrWrite(scrWrite), .scrData(scrData),
  .highRead(highRead), .lowRead(lowRead), .waitMode(waitMode), .stopMode(stopMode),
  .statusCtrl_ff(statusCtrl_ff), .completeFlag_ff(completeFlag_ff),
  .clockReg_ff(clockReg_ff), .resultHigh_ff(resultHigh_ff), .resultLow_ff(resultLow_ff),
  .irqRequest_ff(irqRequest_ff), .wakeRequest_ff(wakeRequest_ff), .dacCode_ff(dacCode_ff),
  .sampleEnable_ff(sampleEnable_ff), .converterOn_ff(converterOn_ff)
);

`default_nettype wire

// File: dv/sar_adc_conversion_control_bench.sv
// self-checking bench for the converter control block
// assumes: inputs driven at the falling edge, comparator from the model
`include "sar_adc_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module sar_adc_conversion_control_bench;
  logic core_clk = 1'b0, rst = 1'b1, scrWrite = 1'b0, clkRegWrite = 1'b0;
  logic highRead = 1'b0, lowRead = 1'b0, busTick = 1'b1, oscTick = 1'b0;
  logic waitMode = 1'b0, stopMode = 1'b0, compHigh, completeFlag_ff, irqRequest_ff;
  logic wakeRequest_ff, sampleEnable_ff, converterOn_ff;
  logic [7:0] resultHigh_ff, resultLow_ff;
  logic [9:0] inputCode = 10'h000, dacCode_ff, codes [4] = '{10'h3ff, 10'h000, 10'h2c5, 10'h155};
  sar_adc_pkg::status_ctrl_t scrData = '0, statusCtrl_ff;
  sar_adc_pkg::clock_reg_t   clkRegData = '0, clockReg_ff;
  int mismatches = 0, testsRun = 0, n, p;
  logic [15:0] res;

  assign res = {resultHigh_ff, resultLow_ff};

  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // oscillator tick every other cycle, bus tick every cycle
  always @(negedge core_clk) oscTick <= ~oscTick;

  sar_adc_conversion_control dut (.core_clk(core_clk), .rst(rst), .scrWrite(scrWrite),
    .scrData(scrData), .clkRegWrite(clkRegWrite), .clkRegData(clkRegData),
    .highRead(highRead), .lowRead(lowRead), .busTick(busTick), .oscTick(oscTick),
    .waitMode(waitMode), .stopMode(stopMode), .compHigh(compHigh),
    .statusCtrl_ff(statusCtrl_ff), .completeFlag_ff(completeFlag_ff),
    .clockReg_ff(clockReg_ff), .resultHigh_ff(resultHigh_ff), .resultLow_ff(resultLow_ff),
    .irqRequest_ff(irqRequest_ff), .wakeRequest_ff(wakeRequest_ff), .dacCode_ff(dacCode_ff),
    .sampleEnable_ff(sampleEnable_ff), .converterOn_ff(converterOn_ff));
  sar_adc_analog_model analog (.core_clk(core_clk), .inputCode(inputCode),
    .dacCode(dacCode_ff), .converterOn(converterOn_ff), .compHigh(compHigh));

  // -------------------------------------------------------------
  // access tasks
  // -------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_scr(input logic ie, input logic co, input logic [4:0] ch);
    @(negedge core_clk);
    scrData = '{ie, co, ch};
    scrWrite = 1'b1;
    @(negedge core_clk);
    scrWrite = 1'b0;
  endtask
  task automatic wr_clk(input logic [1:0] f, input logic src, input logic [2:0] dv);
    @(negedge core_clk);
    clkRegData = '{sar_adc_pkg::format_t'(f), src, dv};
    clkRegWrite = 1'b1;
    @(negedge core_clk);
    clkRegWrite = 1'b0;
  endtask
  task automatic rd(input logic hi);
    @(negedge core_clk);
    highRead = hi;
    lowRead = !hi;
    @(negedge core_clk);
    highRead = 1'b0;
    lowRead = 1'b0;
  endtask
  task automatic wait_flag(output int cnt);
    cnt = 0;
    do begin
      @(negedge core_clk);
      cnt++;
    end while (completeFlag_ff !== 1'b1 && irqRequest_ff !== 1'b1 && cnt < 600);
    chk("done in time", 16'h1, {15'h0, completeFlag_ff || irqRequest_ff});
  endtask
  function automatic logic [15:0] exp_res(input logic [9:0] c, input logic [1:0] f);
    case (f)
      2'h0: return {c[9:2], c[1:0], 6'h00};
      2'h1: return {6'h00, c};
      2'h2: return {~c[9], c[8:2], c[1:0], 6'h00};
      default: return {8'h00, c[9:2]};
    endcase
  endfunction
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    for (int c = 0; c < 4; c++) begin
      for (int f = 0; f < 4; f++) begin
        inputCode = codes[c];
        wr_clk(f[1:0], 1'b1, 3'h0);
        wr_scr(1'b0, 1'b0, 5'h03);
        wait_flag(n);
        chk("result", exp_res(codes[c], f[1:0]), res);
        rd(1'b1);
        rd(1'b0);
        chk("flag after read", 16'h0, {15'h0, completeFlag_ff});
      end
    end
    repeat (60) @(negedge core_clk);
    chk("single idle", 16'h0, {15'h0, completeFlag_ff});
    $display("test formats done");
    for (int d = 0; d < 5; d++) begin
      p = (1 << d) * (d[0] ? 1 : 2);
      wr_clk(2'h1, d[0], d[2:0]);
      wr_scr(1'b0, 1'b0, 5'h03);
      wait_flag(n);
      chk("conv time", 16'h1, {15'h0, n >= 16 * p && n <= 17 * p + 3});
      rd(1'b0);
    end
    $display("test timing done");
    wr_clk(2'h1, 1'b1, 3'h0);
    inputCode = 10'h1a5;
    wr_scr(1'b0, 1'b1, 5'h03);
    wait_flag(n);
    inputCode = 10'h05a;
    repeat (40) @(negedge core_clk);
    chk("overwrite", exp_res(10'h05a, 2'h1), {resultHigh_ff, resultLow_ff});
    wr_clk(2'h0, 1'b1, 3'h0);
    inputCode = 10'h2f0;
    repeat (40) @(negedge core_clk);
    rd(1'b1);
    inputCode = 10'h10f;
    repeat (60) @(negedge core_clk);
    chk("locked", exp_res(10'h2f0, 2'h0), {resultHigh_ff, resultLow_ff});
    rd(1'b0);
    repeat (40) @(negedge core_clk);
    chk("unlocked", exp_res(10'h10f, 2'h0), {resultHigh_ff, resultLow_ff});
    wr_clk(2'h3, 1'b1, 3'h0);
    rd(1'b1);
    inputCode = 10'h3c3;
    repeat (40) @(negedge core_clk);
    chk("trunc no lock", exp_res(10'h3c3, 2'h3), {resultHigh_ff, resultLow_ff});
    wr_scr(1'b0, 1'b0, 5'h1f);
    waitMode = 1'b1;
    rd(1'b0);
    chk("power off", 16'h0, {15'h0, converterOn_ff});
    chk("status readback", 16'h001f, {9'h000, statusCtrl_ff});
    chk("clock readback", 16'h0038, {10'h000, clockReg_ff});
    repeat (60) @(negedge core_clk);
    chk("off no result", 16'h0, {15'h0, completeFlag_ff});
    chk("off no wake", 16'h0, {15'h0, wakeRequest_ff});
    $display("test continuous done");
    wr_clk(2'h1, 1'b1, 3'h0);
    wr_scr(1'b1, 1'b0, 5'h03);
    wait_flag(n);
    @(negedge core_clk);
    chk("irq", 16'h1, {15'h0, irqRequest_ff});
    chk("flag with irq", 16'h0, {15'h0, completeFlag_ff});
    chk("wake", 16'h1, {15'h0, wakeRequest_ff});
    rd(1'b0);
    chk("irq read clear", 16'h0, {15'h0, irqRequest_ff});
    wr_scr(1'b1, 1'b0, 5'h03);
    wait_flag(n);
    wr_scr(1'b1, 1'b0, 5'h03);
    chk("irq write clear", 16'h0, {15'h0, irqRequest_ff});
    waitMode = 1'b0;
    $display("test interrupt done");
    wr_scr(1'b0, 1'b0, 5'h03);
    repeat (8) @(negedge core_clk);
    stopMode = 1'b1;
    inputCode = 10'h0f0;
    repeat (40) @(negedge core_clk);
    chk("stop abort", 16'h0, {15'h0, completeFlag_ff});
    stopMode = 1'b0;
    wait_flag(n);
    chk("stop resume", 16'h1, {15'h0, completeFlag_ff});
    chk("stop result", exp_res(10'h0f0, 2'h1), res);
    $display("test stop done");
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end
endmodule

`default_nettype wire
